// ---- logic/rcs_pkg.sv ----
/*
  Package for the room controller status and command-value output block:
  timing constants, status format and single-status selector encodings,
  bit positions of the status objects.
  Assumes a 25 MHz system clock.
*/
package rcs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned TICK_S = 30;
  localparam longint unsigned TICK_CYC_DEF = longint'(TICK_S) * longint'(CLK_HZ);
  localparam int unsigned INIT_CYC_DEF = 1000;

  // ****************************************************************
  // Status formats and selectors
  // ****************************************************************
  typedef enum logic [1:0] {
    RCS_FMT_OFF = 2'h0,
    RCS_FMT_STD = 2'h1,
    RCS_FMT_GEN = 2'h2,
    RCS_FMT_ONE = 2'h3
  } rcs_fmt_t;

  typedef enum logic [2:0] {
    RCS_SEL_COMFORT = 3'h0,
    RCS_SEL_STANDBY = 3'h1,
    RCS_SEL_NIGHT = 3'h2,
    RCS_SEL_PROT = 3'h3,
    RCS_SEL_DISABLED = 3'h4,
    RCS_SEL_HEATCOOL = 3'h5,
    RCS_SEL_INACTIVE = 3'h6,
    RCS_SEL_FROST = 3'h7
  } rcs_sel_t;

  // Operating mode binary codes
  typedef enum logic [1:0] {
    RCS_MODE_COMFORT = 2'h0,
    RCS_MODE_STANDBY = 2'h1,
    RCS_MODE_NIGHT = 2'h2,
    RCS_MODE_PROT = 2'h3
  } rcs_mode_t;

  // Heating/cooling configuration
  typedef enum logic [1:0] {
    RCS_HC_HEAT = 2'h0,
    RCS_HC_COOL = 2'h1,
    RCS_HC_BOTH = 2'h2
  } rcs_hc_t;

  // ****************************************************************
  // Bit positions
  // ****************************************************************
  localparam int unsigned STD_ERR = 0;
  localparam int unsigned STD_HEAT = 8;
  localparam int unsigned STD_DIS = 12;
  localparam int unsigned STD_FROST = 13;
  localparam int unsigned STD_HEATAL = 14;
  localparam int unsigned GEN_DIS = 4;
  localparam int unsigned GEN_HEAT = 5;
  localparam int unsigned GEN_DEAD = 6;
  localparam int unsigned GEN_FROST = 7;
  localparam logic [15:0] STD_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;

endpackage : rcs_pkg

// ---- logic/rcs_status_out.sv ----
/*
  Room controller command-value scheduling and status telegram output.
  The controller algorithm supplies modes, alarms and the raw command
  value; this block samples them on a 30 s tick and issues send pulses.
  Assumes all inputs are synchronous to clock and stable when sampled.
*/
// Contract
// R1: PWM: recompute every 30 s, update output only at PWM cycle end.
// R2: PWM: no change or periodic sends; separate PWM period setting. The code sends on a value change at PWM cycle end.
// R3: Two-point: evaluate hysteresis every 30 s, switch only then.
// R4: Two-point: no change threshold; send on change, optional repeat.
// R5: Two-point: resend every cycle time; zero disables resending.
// R6: Format select enables status output and picks one of three formats.
// R7: Standard word: only bits 0, 8, 12, 13, 14 may be nonzero.
// R8: Word bit 0 controller error; bit 8 heating one, cooling zero.
// R9: Word bit 12 set while disabled for dew point.
// R10: Word bit 13 frost undershoot; bit 14 heat alarm.
// R11: Standard format also sends mode and forced-mode bytes.
// R12: General byte bits 0-3 one-hot mode; bit 4 disabled.
// R13: General byte bit 5 heating, bit 6 deadband, bit 7 frost.
// R14: Additional byte carries forced, extension, presence, window, level, heat, dew.
// R15: Single format drives configured bit; comfort includes comfort extension.
// R16: Single heat/cool bit is zero while disabled.
// R17: Single inactive bit only in combined mode deadband, not disabled.
// R18: Frost alarm at or below +5 C; no control effect.
// R19: Status first sent after init phase, then every 30 s.
// R20: Status telegram only when value differs from last sent.
// R21: Last sent status held in registers, loaded at first send.
`timescale 1ns/1ps
module rcs_status_out #(
  parameter longint unsigned TICK_CYC = rcs_pkg::TICK_CYC_DEF,
  parameter int unsigned INIT_CYC = rcs_pkg::INIT_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic alg_pwm,
  input wire logic [7:0] cv_pi,
  input wire logic [23:0] pwm_period_cyc,
  input wire logic tp_demand,
  input wire logic [7:0] resend_ticks,
  input wire logic [1:0] status_fmt,
  input wire logic [2:0] single_sel,
  input wire logic [1:0] op_mode,
  input wire logic forced_mode,
  input wire logic [7:0] forced_code,
  input wire logic [7:0] mode_code,
  input wire logic [1:0] hc_cfg,
  input wire logic heating,
  input wire logic ctrl_err,
  input wire logic ctrl_disabled,
  input wire logic frost_low,
  input wire logic heat_alarm,
  input wire logic in_deadband,
  input wire logic comfort_ext,
  input wire logic pres_det,
  input wire logic pres_btn,
  input wire logic window_open,
  input wire logic add_level,
  input wire logic heat_prot,
  output logic pwm_out,
  output logic [7:0] cv_byte,
  output logic cv_bit,
  output logic cv_send,
  output logic [15:0] std_word,
  output logic std_word_send,
  output logic [7:0] std_mode,
  output logic std_mode_send,
  output logic [7:0] std_forced,
  output logic std_forced_send,
  output logic [7:0] gen_status,
  output logic gen_status_send,
  output logic [7:0] gen_add,
  output logic gen_add_send,
  output logic single_bit,
  output logic single_send
);

  localparam int unsigned TW = $clog2(TICK_CYC + 1);
  localparam int unsigned IW = $clog2(INIT_CYC + 1);

  // ****************************************************************
  // Init phase and 30 s tick
  // ****************************************************************
  logic init_done_r;
  logic first_r;
  logic tick;
  logic init_pulse;

  rcs_tick #(.W(IW)) u_init (
    .clock(clock),
    .rst_n(rst_n),
    .run(!init_done_r),
    .period(IW'(INIT_CYC)),
    .pulse(init_pulse)
  );

  // R19 tick only after init
  rcs_tick #(.W(TW)) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .run(init_done_r),
    .period(TW'(TICK_CYC)),
    .pulse(tick)
  );

  // Init completion latches; first_r marks the forced first evaluation
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      init_done_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      if (init_pulse) init_done_r <= 1'b1;
      first_r <= init_pulse;
    end
  end

  // Evaluation instant: end of init, then every tick
  wire eval = first_r | tick;

  // ****************************************************************
  // Switching PI (PWM)
  // ****************************************************************
  logic [7:0] cv_calc_r;
  logic [23:0] pwm_cnt_r;
  wire pwm_end = (pwm_cnt_r >= pwm_period_cyc - 24'h000001);
  // Duty threshold: cv_byte/255 of the period, rounded down
  wire [31:0] duty_full = pwm_period_cyc * cv_byte;
  wire [23:0] duty_cyc = 24'(duty_full / 32'h000000FF);

  // R1 command value recomputed on tick, applied at PWM end
  // R2 change send at PWM cycle end, no cyclic sends; period from its own setting
  always_ff @(posedge clock) begin
    if (!rst_n || !alg_pwm) begin
      cv_calc_r <= 8'h00;
      pwm_cnt_r <= 24'h000000;
    end else begin
      if (eval) cv_calc_r <= cv_pi;
      pwm_cnt_r <= pwm_end ? 24'h000000 : pwm_cnt_r + 24'h000001;
    end
  end

  // ****************************************************************
  // Two-point control and periodic resend
  // ****************************************************************
  logic [7:0] rep_cnt_r;
  wire rep_due = (resend_ticks != 8'h00) && (rep_cnt_r + 8'h01 >= resend_ticks);
  wire tp_change = eval && (tp_demand != cv_bit);

  // Output registers for command values
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cv_byte <= 8'h00;
      cv_bit <= 1'b0;
      pwm_out <= 1'b0;
      cv_send <= 1'b0;
      rep_cnt_r <= 8'h00;
    end else if (alg_pwm) begin
      rep_cnt_r <= 8'h00;
      // R1 update only at end of PWM cycle
      if (pwm_end) cv_byte <= cv_calc_r;
      pwm_out <= (pwm_cnt_r < duty_cyc) && (cv_byte != 8'h00);
      cv_bit <= 1'b0;
      cv_send <= pwm_end && (cv_byte != cv_calc_r);
    end else begin
      pwm_out <= 1'b0;
      cv_byte <= {8{cv_bit}};
      // R3 switch value changes only at evaluation
      if (eval) cv_bit <= tp_demand;
      // R4 R5 change send, plus repeat every resend_ticks ticks
      cv_send <= tp_change || (tick && rep_due);
      // Frozen while resending is off; only a change send clears it, otherwise the count resumes when resending is enabled again
      if (tp_change || (tick && rep_due)) rep_cnt_r <= 8'h00;
      else if (tick && resend_ticks != 8'h00) rep_cnt_r <= rep_cnt_r + 8'h01;
    end
  end

  // ****************************************************************
  // Status word and bytes (combinational)
  // ****************************************************************
  wire mode_comfort = (op_mode == rcs_pkg::RCS_MODE_COMFORT);
  wire mode_standby = (op_mode == rcs_pkg::RCS_MODE_STANDBY);
  wire mode_night = (op_mode == rcs_pkg::RCS_MODE_NIGHT);
  wire mode_prot = (op_mode == rcs_pkg::RCS_MODE_PROT);
  // R17 deadband only in combined mode and enabled
  wire inactive = (hc_cfg == rcs_pkg::RCS_HC_BOTH) && in_deadband && !ctrl_disabled;
  // R16 heat/cool forced low while disabled
  wire heat_sgl = heating && !ctrl_disabled;

  // R7 R8 R9 R10 only five bits may be nonzero
  logic [15:0] std_new;
  always_comb begin
    std_new = rcs_pkg::STD_RST;
    std_new[rcs_pkg::STD_ERR] = ctrl_err;
    std_new[rcs_pkg::STD_HEAT] = heating;
    std_new[rcs_pkg::STD_DIS] = ctrl_disabled;
    std_new[rcs_pkg::STD_FROST] = frost_low;
    std_new[rcs_pkg::STD_HEATAL] = heat_alarm;
  end

  // R12 R13 general status byte; R18 frost is status only
  wire [7:0] gen_new = {frost_low, inactive, heating, ctrl_disabled,
                        mode_prot, mode_night, mode_standby, mode_comfort};
  // R14 additional status byte
  wire [7:0] add_new = {ctrl_disabled, heat_prot, add_level, window_open,
                        pres_btn, pres_det, comfort_ext, !forced_mode};

  // R15 single bit selection
  logic sgl_new;
  always_comb begin
    unique case (rcs_pkg::rcs_sel_t'(single_sel))
      rcs_pkg::RCS_SEL_COMFORT: sgl_new = mode_comfort | comfort_ext;
      rcs_pkg::RCS_SEL_STANDBY: sgl_new = mode_standby;
      rcs_pkg::RCS_SEL_NIGHT: sgl_new = mode_night;
      rcs_pkg::RCS_SEL_PROT: sgl_new = mode_prot;
      rcs_pkg::RCS_SEL_DISABLED: sgl_new = ctrl_disabled;
      rcs_pkg::RCS_SEL_HEATCOOL: sgl_new = heat_sgl;
      rcs_pkg::RCS_SEL_INACTIVE: sgl_new = inactive;
      rcs_pkg::RCS_SEL_FROST: sgl_new = frost_low;
    endcase
  end

  // R6 format enables
  wire f_std = (status_fmt == rcs_pkg::RCS_FMT_STD);
  wire f_gen = (status_fmt == rcs_pkg::RCS_FMT_GEN);
  wire f_one = (status_fmt == rcs_pkg::RCS_FMT_ONE);

  // R20 send only on difference; first evaluation always sends
  wire s_word = eval && f_std && (first_r || std_new != std_word);
  wire s_mode = eval && f_std && (first_r || mode_code != std_mode);
  wire s_forc = eval && f_std && (first_r || forced_code != std_forced);
  wire s_gen = eval && f_gen && (first_r || gen_new != gen_status);
  wire s_add = eval && f_gen && (first_r || add_new != gen_add);
  wire s_one = eval && f_one && (first_r || sgl_new != single_bit);

  // ****************************************************************
  // Last-sent registers, which are also the telegram outputs
  // ****************************************************************
  // R21 hold last transmitted value for comparison
  // R11 mode and forced-mode bytes
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      std_word <= rcs_pkg::STD_RST;
      std_mode <= rcs_pkg::BYTE_RST;
      std_forced <= rcs_pkg::BYTE_RST;
      gen_status <= rcs_pkg::BYTE_RST;
      gen_add <= rcs_pkg::BYTE_RST;
      single_bit <= 1'b0;
    end else begin
      if (s_word) std_word <= std_new;
      if (s_mode) std_mode <= mode_code;
      if (s_forc) std_forced <= forced_code;
      if (s_gen) gen_status <= gen_new;
      if (s_add) gen_add <= add_new;
      if (s_one) single_bit <= sgl_new;
    end
  end

  // Send strobes, one cycle, aligned with the new value
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      std_word_send <= 1'b0;
      std_mode_send <= 1'b0;
      std_forced_send <= 1'b0;
      gen_status_send <= 1'b0;
      gen_add_send <= 1'b0;
      single_send <= 1'b0;
    end else begin
      std_word_send <= s_word;
      std_mode_send <= s_mode;
      std_forced_send <= s_forc;
      gen_status_send <= s_gen;
      gen_add_send <= s_add;
      single_send <= s_one;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_std_zero_bits: assert property (@(posedge clock) disable iff (!rst_n) // R7
    (std_word & 16'h8EFE) == 16'h0000) else $error("reserved status bit set");
  a_word_on_change: assert property (@(posedge clock) disable iff (!rst_n) // R20
    std_word_send && !$past(first_r) |-> std_word != $past(std_word)) else $error("unchanged word sent");
  a_send_on_eval: assert property (@(posedge clock) disable iff (!rst_n) // R19
    gen_status_send |-> $past(eval)) else $error("status sent off tick");
  a_hc_disabled: assert property (@(posedge clock) disable iff (!rst_n) // R16
    single_send && single_sel == 3'h5 && $past(ctrl_disabled) |-> !single_bit) else $error("heat bit while off");
  a_inactive_mode: assert property (@(posedge clock) disable iff (!rst_n) // R17
    gen_status_send && $past(hc_cfg) != 2'h2 |-> !gen_status[6]) else $error("deadband outside combined");
  a_tp_switch: assert property (@(posedge clock) disable iff (!rst_n) // R3
    !alg_pwm && $past(!alg_pwm) && cv_bit != $past(cv_bit) |-> $past(eval)) else $error("switch off tick");
  a_pwm_update: assert property (@(posedge clock) disable iff (!rst_n) // R1
    alg_pwm && $past(alg_pwm) && cv_byte != $past(cv_byte) |-> $past(pwm_end)) else $error("pwm update mid cycle");
  a_no_resend0: assert property (@(posedge clock) disable iff (!rst_n) // R5
    !alg_pwm && $past(!alg_pwm) && $past(resend_ticks) == 8'h00 && cv_send |-> $past(tp_change))
    else $error("resend with zero cycle");
  a_gen_bits: assert property (@(posedge clock) disable iff (!rst_n) // R13
    gen_status_send |-> gen_status[5] == $past(heating) && gen_status[7] == $past(frost_low))
    else $error("general byte wrong");

endmodule : rcs_status_out

// ---- logic/rcs_tick.sv ----
/*
  Cycle counter producing a one-cycle pulse when a programmable count
  elapses. Used for the 30 s evaluation tick and the init phase.
  Assumes synchronous active-low reset and a single clock.
*/
`timescale 1ns/1ps
module rcs_tick #(
  parameter int unsigned W = 30
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] period,
  output logic pulse
);

  logic [W-1:0] cnt_r;
  wire last = (cnt_r >= period - W'(1));

  // ****************************************************************
  // Counter; stopped counter restarts from zero
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (!rst_n || !run) begin
      cnt_r <= '0;
      pulse <= 1'b0;
    end else begin
      cnt_r <= last ? '0 : cnt_r + W'(1);
      pulse <= last;
    end
  end

endmodule : rcs_tick

// ---- test/rcs_sink.sv ----
/*
  Telegram sink standing for the bus actuators and extension displays.
  Assumes one-cycle send pulses, synchronous to clock.
*/
`timescale 1ns/1ps
module rcs_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cv_send,
  input wire logic std_send,
  input wire logic gen_send,
  input wire logic one_send,
  input wire logic add_send,
  output int n_add,
  output int n_cv,
  output int n_std,
  output int n_gen,
  output int n_one
);
  // ************************************************************
  // Telegram counters
  // ************************************************************
  // Counting only: the bench reads values at the ports, so no copy is kept here
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      n_cv <= 0;
      n_std <= 0;
      n_gen <= 0;
      n_one <= 0;
      n_add <= 0;
    end else begin
      n_add <= n_add + int'(add_send);
      n_cv <= n_cv + int'(cv_send);
      n_std <= n_std + int'(std_send);
      n_gen <= n_gen + int'(gen_send);
      n_one <= n_one + int'(one_send);
    end
  end
endmodule : rcs_sink

// ---- test/tb.sv ----
/*
  Self-checking bench for the status and command-value block.
  Assumes shortened tick and init counts; inputs move 1 ns after the edge.
*/
`timescale 1ns/1ps
module tb;
  localparam int TICK = 50;
  localparam int INIT = 10;
  logic clock = 1'b0;
  logic rst_n, alg_pwm, tp_demand, forced_mode, heating, ctrl_err, ctrl_disabled, frost_low, heat_alarm;
  logic in_deadband, comfort_ext, pres_det, pres_btn, window_open, add_level, heat_prot;
  logic [7:0] cv_pi, resend_ticks, forced_code, mode_code, cv_byte, std_mode, std_forced, gen_status, gen_add;
  logic [23:0] pwm_period_cyc;
  logic [1:0] status_fmt, op_mode, hc_cfg;
  logic [2:0] single_sel;
  logic [15:0] std_word;
  logic pwm_out, cv_bit, cv_send, std_word_send, std_mode_send, std_forced_send;
  logic gen_status_send, gen_add_send, single_bit, single_send;
  int n_cv, n_std, n_gen, n_one, n_add, n0, i;
  int err_total = 0;
  int compares = 0;

  // ************************************************************
  // Clock, design and sink
  // ************************************************************
  always #20 clock = ~clock;

  rcs_status_out #(.TICK_CYC(TICK), .INIT_CYC(INIT)) rcs_status_out_inst (.clock, .rst_n, .alg_pwm, .cv_pi,
    .pwm_period_cyc, .tp_demand, .resend_ticks, .status_fmt, .single_sel, .op_mode, .forced_mode, .forced_code,
    .mode_code, .hc_cfg, .heating, .ctrl_err, .ctrl_disabled, .frost_low, .heat_alarm, .in_deadband,
    .comfort_ext, .pres_det, .pres_btn, .window_open, .add_level, .heat_prot, .pwm_out, .cv_byte, .cv_bit,
    .cv_send, .std_word, .std_word_send, .std_mode, .std_mode_send, .std_forced, .std_forced_send,
    .gen_status, .gen_status_send, .gen_add, .gen_add_send, .single_bit, .single_send);

  rcs_sink rcs_sink_inst (.clock, .rst_n, .cv_send, .std_send(std_word_send), .gen_send(gen_status_send),
    .one_send(single_send), .add_send(gen_add_send), .n_add, .n_cv, .n_std, .n_gen, .n_one);

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  // Long enough that one evaluation and its answer surely fall inside
  task automatic tickw;
    step(TICK + 3);
  endtask : tickw

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic exp_one(input logic [2:0] s);
    logic [7:0] v;
    v = {frost_low, hc_cfg == rcs_pkg::RCS_HC_BOTH && in_deadband && !ctrl_disabled,
      heating && !ctrl_disabled, ctrl_disabled, op_mode == 2'h3, op_mode == 2'h2, op_mode == 2'h1,
      op_mode == 2'h0 || comfort_ext};
    return v[s];
  endfunction : exp_one

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // ************************************************************
  // Scenarios
  // ************************************************************
  // First refresh comes only after the init phase, and carries the word
  task automatic t_std_first;
    for (i = 0; i < INIT + TICK && std_word_send !== 1'b1; i++) begin
      step(1);
    end
    if (std_word_send !== 1'b1) begin
      chk(16'h0, 16'h1);
      conclude();
    end else begin
      chk(16'(i >= INIT && i <= INIT + 4), 16'h1);
      chk(std_word, 16'h3001);
      chk({std_mode, std_forced}, 16'h0300);
      chk(16'({std_mode_send, std_forced_send}), 16'h3);
    end
  endtask : t_std_first

  // Quiet while unchanged, one telegram on a change
  task automatic t_std_change;
    // The sink counts one edge after the pulse, so let the first telegram land
    step(1);
    n0 = n_std;
    tickw();
    tickw();
    chk(16'(n_std - n0), 16'h0);
    heating = 1'b1;
    heat_alarm = 1'b1;
    ctrl_disabled = 1'b0;
    ctrl_err = 1'b0;
    tickw();
    chk(16'(n_std - n0), 16'h1);
    chk(std_word, 16'h6100);
  endtask : t_std_change

  task automatic t_gen;
    int ns, ng, na;
    ns = n_std;
    ng = n_gen;
    na = n_add;
    status_fmt = rcs_pkg::RCS_FMT_GEN;
    {op_mode, hc_cfg, in_deadband, comfort_ext, pres_btn, add_level} = {2'h1, 2'h2, 4'hF};
    tickw();
    chk(gen_status, 8'hE2);
    chk(gen_add, 8'h2B);
    {op_mode, ctrl_disabled, heating, in_deadband, forced_mode} = {2'h3, 4'h9};
    tickw();
    chk(gen_status, 8'h98);
    chk(gen_add, 8'hAA);
    // Heating only: the deadband bit stays clear even inside the band
    {hc_cfg, ctrl_disabled, in_deadband, pres_det, window_open, heat_prot} = {2'h0, 5'h0F};
    tickw();
    chk(gen_status, 8'h88);
    chk(gen_add, 8'h7E);
    chk(16'(n_gen - ng), 16'h3);
    chk(16'(n_add - na), 16'h3);
    chk(16'(n_std - ns), 16'h0);
  endtask : t_gen

  // Every selector, with the controller enabled, disabled, and heating only
  task automatic t_single;
    logic pv;
    int ne, n1;
    pv = 1'b0;
    ne = 0;
    n1 = n_one;
    status_fmt = rcs_pkg::RCS_FMT_ONE;
    {op_mode, heating, in_deadband} = {2'h2, 2'h3};
    for (int d = 0; d < 3; d++) begin
      for (int s = 0; s < 8; s++) begin
        ctrl_disabled = (d == 1);
        hc_cfg = (d == 2) ? rcs_pkg::RCS_HC_HEAT : rcs_pkg::RCS_HC_BOTH;
        single_sel = 3'(s);
        tickw();
        chk(16'(single_bit), 16'(exp_one(3'(s))));
        // Tally the expected telegrams: one per change of the selected bit
        ne += int'(exp_one(3'(s)) !== pv);
        pv = exp_one(3'(s));
      end
    end
    chk(16'(n_one - n1), 16'(ne));
  endtask : t_single

  task automatic t_two_point;
    int nq;
    // Status output off: a change of the selected bit must stay silent
    nq = n_one;
    status_fmt = rcs_pkg::RCS_FMT_OFF;
    frost_low = 1'b0;
    tp_demand = 1'b1;
    tickw();
    chk(16'(cv_bit), 16'h1);
    tp_demand = 1'b0;
    tickw();
    chk(16'(cv_bit), 16'h0);
    n0 = n_cv;
    step(TICK * 3);
    chk(16'(n_cv - n0), 16'h0);
    resend_ticks = 8'h02;
    n0 = n_cv;
    step(TICK * 4);
    chk(16'(n_cv - n0), 16'h2);
    chk(16'(n_one - nq), 16'h0);
    chk(16'(single_bit), 16'h1);
  endtask : t_two_point

  task automatic t_pwm;
    alg_pwm = 1'b1;
    cv_pi = 8'h80;
    step(TICK * 2);
    chk(16'(cv_byte), 16'h80);
    n0 = n_cv;
    step(TICK * 4);
    chk(16'(n_cv - n0), 16'h0);
    n0 = 0;
    repeat (40) begin
      n0 += int'(pwm_out === 1'b1);
      step(1);
    end
    chk(16'(n0 >= 19 && n0 <= 21), 16'h1);
  endtask : t_pwm

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    {alg_pwm, tp_demand, forced_mode, heating, heat_alarm, in_deadband, comfort_ext} = 7'h00;
    {pres_det, pres_btn, window_open, add_level, heat_prot} = 5'h00;
    {ctrl_err, ctrl_disabled, frost_low} = 3'h7;
    {cv_pi, resend_ticks, forced_code, mode_code} = 32'h0000_0003;
    pwm_period_cyc = 24'h000014;
    {op_mode, hc_cfg, single_sel} = 7'h00;
    status_fmt = rcs_pkg::RCS_FMT_STD;
    rst_n = 1'b0;
    step(10);
    rst_n = 1'b1;
    t_std_first();
    t_std_change();
    t_gen();
    t_single();
    t_two_point();
    t_pwm();
    conclude();
  end
endmodule : tb
